// [dv/push_rotate_return_exec_test.sv]
/*
  Self-checking bench for the push, carry-clear, return and rotate block.
  Assumes the stack and register model answers combinationally.
*/
`timescale 1ns/1ps
`default_nettype none
module push_rotate_return_exec_test
  import exec_pkg::*;
;
  localparam logic [7:0] RL_T  = 8'h90;
  localparam logic [7:0] RLC_T = 8'h10;

  logic        sys_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        exec_start_i = 1'b0;
  logic [7:0]  opcode_i = 8'h00;
  logic [7:0]  dst_op_i = 8'h00;
  logic [7:0]  src_op_i = 8'h00;
  logic        alt_stack_i = 1'b0;
  logic [7:0]  flags_i = 8'h00;
  logic [15:0] sp_i = 16'h0000;
  logic        busy_o, done_o, illegal_o, rf_we_o, pc_we_o, sp_we_o, flags_we_o;
  logic [7:0]  rf_rdata_i, rf_addr_o, rf_wdata_o, mem_rdata_i, flags_o;
  logic [15:0] mem_addr_o, pc_o, sp_o;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;
  int          busy_n, done_n, ill_n, flw_n, pcw_n;
  logic [7:0]  flags_cap;
  logic [15:0] pc_cap, sp_cap;

  always #2.5 sys_clk_i = ~sys_clk_i;

  push_rotate_return_exec #(.RL_OPC(RL_T), .RLC_OPC(RLC_T)) u_push_rotate_return_exec (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .exec_start_i(exec_start_i), .opcode_i(opcode_i),
    .dst_op_i(dst_op_i), .src_op_i(src_op_i), .alt_stack_i(alt_stack_i), .flags_i(flags_i),
    .sp_i(sp_i), .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o), .rf_rdata_i(rf_rdata_i),
    .rf_addr_o(rf_addr_o), .rf_wdata_o(rf_wdata_o), .rf_we_o(rf_we_o), .mem_rdata_i(mem_rdata_i),
    .mem_addr_o(mem_addr_o), .pc_o(pc_o), .pc_we_o(pc_we_o), .sp_o(sp_o), .sp_we_o(sp_we_o),
    .flags_o(flags_o), .flags_we_o(flags_we_o));

  stack_reg_model u_stack_reg_model (
    .sys_clk_i(sys_clk_i), .rf_addr_i(rf_addr_o), .rf_wdata_i(rf_wdata_o), .rf_we_i(rf_we_o),
    .rf_rdata_o(rf_rdata_i), .mem_addr_i(mem_addr_o), .mem_rdata_o(mem_rdata_i));

  // ==========================================================================
  // Checking helpers
  task automatic results();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val

  task automatic chk_cnt(input string nm, input int e, input int g);
    checked++;
    if (g != e)
    begin
      err_total++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_cnt

  // Returns the carry out above the rotated byte.
  function automatic logic [8:0] rot_exp(input logic [1:0] m, input logic [7:0] d, input logic c);
    case (m)
      2'h1: rot_exp = {d[7], d[6:0], d[7]};
      2'h2: rot_exp = {d[7], d[6:0], c};
      default: rot_exp = {d[0], d[0], d[7:1]};
    endcase
  endfunction : rot_exp

  function automatic logic [7:0] flg_exp(input logic [7:0] f, input logic [7:0] d, input logic [8:0] r);
    flg_exp = f;
    flg_exp[FLG_C] = r[8];
    flg_exp[FLG_Z] = (r[7:0] == 8'h00);
    flg_exp[FLG_S] = r[7];
    flg_exp[FLG_V] = d[7] ^ r[7];
  endfunction : flg_exp

  // Strobes are counted at the edge that samples them, so one-cycle pulses are never missed.
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (busy_o === 1'b1) busy_n++;
    if (done_o === 1'b1) done_n++;
    if (illegal_o === 1'b1) ill_n++;
    if (flags_we_o === 1'b1)
    begin
      flw_n++;
      flags_cap = flags_o;
    end
    if (pc_we_o === 1'b1)
    begin
      pcw_n++;
      pc_cap = pc_o;
    end
    // The stack pointer is captured on its own strobe, so a missing strobe leaves a stale value.
    if (sp_we_o === 1'b1)
      sp_cap = sp_o;
    // The ceiling sits far above the few hundred cycles the scenarios need.
    if (cyc > 20000)
    begin
      err_total++;
      results();
    end
  end

  // A poke raises a second start while busy; it must be ignored.
  task automatic issue(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s, input logic alt,
                       input logic [7:0] f, input logic [15:0] sp, input logic poke);
    int i;
    @(negedge sys_clk_i);
    busy_n = 0; done_n = 0; ill_n = 0; flw_n = 0; pcw_n = 0;
    @(posedge sys_clk_i);
    exec_start_i <= 1'b1;
    opcode_i <= op; dst_op_i <= d; src_op_i <= s; alt_stack_i <= alt; flags_i <= f; sp_i <= sp;
    @(posedge sys_clk_i);
    exec_start_i <= poke;
    opcode_i <= OPC_CARRY_CLR;
    @(posedge sys_clk_i);
    exec_start_i <= 1'b0;
    i = 0;
    while (done_n == 0 && i < 20)
    begin
      @(posedge sys_clk_i);
      i++;
    end
    repeat (2) @(posedge sys_clk_i);
  endtask : issue

  // ==========================================================================
  // Main sequence
  logic [7:0]  d, p, v, f, hi, lo, t;
  logic [15:0] sp;
  logic [8:0]  r;
  logic [7:0]  ops [6];
  logic [1:0]  mds [6];
  logic [7:0]  corner [4];

  initial
  begin
    ops = '{OPC_RR_REG, OPC_RR_IND, RL_T, RL_T | OPC_IND_BIT, RLC_T, RLC_T | OPC_IND_BIT};
    mds = '{2'h3, 2'h3, 2'h1, 2'h1, 2'h2, 2'h2};
    corner = '{8'h00, 8'h80, 8'h01, 8'h31};
    void'($urandom(32'h64ccb1af));
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    // Pointers live in 80..FF and operands in 40..7F, so the wrap to 00 never collides.
    for (int k = 0; k < 4; k++)
    begin
      d = 8'h40 | (8'($urandom) & 8'h3E);
      p = (k == 0) ? 8'hFF : (8'h80 | 8'($urandom));
      v = 8'($urandom);
      f = 8'($urandom);
      u_stack_reg_model.rf[d] = p;
      u_stack_reg_model.rf[d ^ 8'h01] = v;
      issue(OPC_PUSH_UP, d, d ^ 8'h01, 1'b0, f, 16'h0000, 1'b0);
      chk_val("push pointer", {8'h00, p + USP_STEP}, {8'h00, u_stack_reg_model.rf[d]});
      chk_val("push data", {8'h00, v}, {8'h00, u_stack_reg_model.rf[p + USP_STEP]});
      chk_cnt("push flag writes", 0, flw_n);
      chk_cnt("push cycles", 8, busy_n);
      chk_cnt("push done pulses", 1, done_n);
    end
    for (int k = 0; k < 4; k++)
    begin
      f = 8'($urandom);
      if (k < 2) f[FLG_C] = k[0];
      issue(OPC_CARRY_CLR, 8'h00, 8'h00, 1'b0, f, 16'h0000, 1'b0);
      t = f;
      t[FLG_C] = 1'b0;
      chk_val("clear flags", {8'h00, t}, {8'h00, flags_cap});
      chk_cnt("clear cycles", 4, busy_n);
      chk_cnt("clear flag writes", 1, flw_n);
      chk_cnt("clear done pulses", 1, done_n);
    end
    for (int k = 0; k < 4; k++)
    begin
      sp = (k == 3) ? 16'hFFFF : 16'($urandom);
      hi = 8'($urandom);
      lo = 8'($urandom);
      u_stack_reg_model.mem[sp] = hi;
      u_stack_reg_model.mem[sp + SP_NEXT] = lo;
      issue(OPC_RETURN, 8'h00, 8'h00, k[0], 8'($urandom), sp, k == 2);
      chk_val("return pc", {hi, lo}, pc_cap);
      chk_val("return sp", sp + SP_STEP, sp_cap);
      chk_cnt("return pc writes", 1, pcw_n);
      chk_cnt("return flag writes", 0, flw_n);
      chk_cnt("return cycles", k[0] ? 10 : 8, busy_n);
      chk_cnt("return done pulses", 1, done_n);
    end
    for (int j = 0; j < 6; j++)
    begin
      for (int k = 0; k < 6; k++)
      begin
        v = (k < 4) ? corner[k] : 8'($urandom);
        f = 8'($urandom);
        d = 8'h40 | (8'($urandom) & 8'h3F);
        p = 8'h80 | 8'($urandom);
        t = ops[j][0] ? p : d;
        u_stack_reg_model.rf[d] = ops[j][0] ? p : v;
        u_stack_reg_model.rf[p] = v;
        r = rot_exp(mds[j], v, f[FLG_C]);
        issue(ops[j], d, 8'h00, 1'b0, f, 16'h0000, 1'b0);
        chk_val("rotate result", {8'h00, r[7:0]}, {8'h00, u_stack_reg_model.rf[t]});
        chk_val("rotate flags", {8'h00, flg_exp(f, v, r)}, {8'h00, flags_cap});
        chk_cnt("rotate cycles", 4, busy_n);
        chk_cnt("rotate flag writes", 1, flw_n);
        chk_cnt("rotate done pulses", 1, done_n);
      end
    end
    issue(8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 16'h0000, 1'b0);
    chk_cnt("unknown opcode pulse", 1, ill_n);
    chk_cnt("unknown opcode busy", 0, busy_n);
    chk_cnt("unknown opcode done", 0, done_n);
    results();
  end
endmodule : push_rotate_return_exec_test
`default_nettype wire

// [dv/stack_reg_model.sv]
/*
  Register file and stack memory model standing beside the execution block.
  Assumes reads follow the addresses combinationally and register writes land on the rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module stack_reg_model
(
  // Clock
  input  wire logic        sys_clk_i,
  // Register file
  input  wire logic [7:0]  rf_addr_i,
  input  wire logic [7:0]  rf_wdata_i,
  input  wire logic        rf_we_i,
  output var  logic [7:0]  rf_rdata_o,
  // Stack memory
  input  wire logic [15:0] mem_addr_i,
  output var  logic [7:0]  mem_rdata_o
);
  // ==========================================================================
  // Storage
  logic [7:0] rf  [256];
  logic [7:0] mem [65536];

  // Read data is always live, so a late read address shows up as a wrong byte.
  assign rf_rdata_o  = rf[rf_addr_i];
  assign mem_rdata_o = mem[mem_addr_i];

  always @(posedge sys_clk_i)
  begin
    if (rf_we_i === 1'b1)
    begin
      rf[rf_addr_i] <= rf_wdata_i;
    end
  end
endmodule : stack_reg_model
`default_nettype wire

// [rtl/exec_pkg.sv]
/*
  Constants, opcodes, flag layout and state encoding for the push, carry-clear,
  return and rotate execution block. Assumes an 8-bit register file and a
  16-bit stack address space outside the block.
*/
// Overview of operation
// - Incrementing push adds one to the user stack pointer before storing.
// - Push stores source into register at the new pointer; flags untouched; opcode 83.
// - Carry-clear forces carry to zero and touches no other flag; opcode CF.
// - Return loads the PC from the stack, then adds two to SP; flags untouched.
// - Byte at SP becomes PC high byte, the next byte the low byte.
// - Execution continues at the reloaded PC; opcode AF, 8 or 10 cycles.
// - Rotate-left moves bit 7 to bit 0 and to the carry.
// - Rotate-left-through-carry puts old carry in bit 0, bit 7 in carry.
// - Rotate-right moves bit 0 to bit 7 and to the carry.
// - After rotate-right Z marks a zero result, S is bit 7, D and H hold.
// - After rotate-right V is set when the sign bit changed.
// - Rotate-right carry is the bit leaving bit 0; opcodes E0 and E1.
package exec_pkg;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OPC_PUSH_UP   = 8'h83;
  localparam logic [7:0] OPC_CARRY_CLR = 8'hCF;
  localparam logic [7:0] OPC_RETURN    = 8'hAF;
  localparam logic [7:0] OPC_RR_REG    = 8'hE0;
  localparam logic [7:0] OPC_RR_IND    = 8'hE1;
  localparam logic [7:0] OPC_IND_BIT   = 8'h01;

  // ==========================================================================
  // Cycle counts
  localparam logic [3:0] CYC_PUSH_UP   = 4'h8;
  localparam logic [3:0] CYC_CARRY_CLR = 4'h4;
  localparam logic [3:0] CYC_RET_INT   = 4'h8;
  localparam logic [3:0] CYC_RET_ALT   = 4'hA;
  localparam logic [3:0] CYC_ROTATE    = 4'h4;
  localparam logic [3:0] CNT_FIRST     = 4'h1;
  localparam logic [3:0] CNT_STEP      = 4'h1;

  // ==========================================================================
  // Flag bit positions and pointer steps
  localparam int FLG_C = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 5;
  localparam int FLG_V = 4;
  localparam int FLG_D = 3;
  localparam int FLG_H = 2;
  localparam logic [7:0]  USP_STEP = 8'h01;
  localparam logic [15:0] SP_STEP  = 16'h0002;
  localparam logic [15:0] SP_NEXT  = 16'h0001;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {ROT_NONE = 2'h0, ROT_RL = 2'h1, ROT_RLC = 2'h2, ROT_RR = 2'h3} rot_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_A    = 3'h1,
    ST_B    = 3'h3,
    ST_C    = 3'h2,
    ST_W    = 3'h6
  } exec_state_t;

endpackage : exec_pkg

// [rtl/push_rotate_return_exec.sv]
/*
  Sequencer for incrementing user push, carry clear, return and the byte
  rotates. Assumes the register file and stack memory read combinationally
  from the registered addresses, and writes take effect on the write strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module push_rotate_return_exec
  import exec_pkg::*;
#(
  parameter logic [7:0] RL_OPC  = 8'h90,
  parameter logic [7:0] RLC_OPC = 8'h10
)
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // Instruction issue
  input  wire logic        exec_start_i,
  input  wire logic [7:0]  opcode_i,
  input  wire logic [7:0]  dst_op_i,
  input  wire logic [7:0]  src_op_i,
  input  wire logic        alt_stack_i,
  input  wire logic [7:0]  flags_i,
  input  wire logic [15:0] sp_i,
  output var  logic        busy_o,
  output var  logic        done_o,
  output var  logic        illegal_o,
  // Register file
  input  wire logic [7:0]  rf_rdata_i,
  output var  logic [7:0]  rf_addr_o,
  output var  logic [7:0]  rf_wdata_o,
  output var  logic        rf_we_o,
  // Stack memory and program counter
  input  wire logic [7:0]  mem_rdata_i,
  output var  logic [15:0] mem_addr_o,
  output var  logic [15:0] pc_o,
  output var  logic        pc_we_o,
  output var  logic [15:0] sp_o,
  output var  logic        sp_we_o,
  // Flags
  output var  logic [7:0]  flags_o,
  output var  logic        flags_we_o
);

  // ==========================================================================
  // Elaboration checks
  if (RL_OPC[0] || RLC_OPC[0] || RL_OPC == RLC_OPC)
    $error("left rotate opcodes must be even and distinct");
  // A left rotate pair that overlaps a fixed opcode would decode as two instructions at once.
  if (((RL_OPC | OPC_IND_BIT) inside {OPC_PUSH_UP, OPC_CARRY_CLR, OPC_RETURN, OPC_RR_IND})
      || ((RLC_OPC | OPC_IND_BIT) inside {OPC_PUSH_UP, OPC_CARRY_CLR, OPC_RETURN, OPC_RR_IND}))
    $error("left rotate opcodes collide with a fixed opcode");

  // ==========================================================================
  // Decode
  function automatic rot_mode_t rot_of(input logic [7:0] op);
    logic [7:0] base;
    base = op & ~OPC_IND_BIT;
    if (base == OPC_RR_REG)
      return ROT_RR;
    else if (base == RL_OPC)
      return ROT_RL;
    else if (base == RLC_OPC)
      return ROT_RLC;
    else
      return ROT_NONE;
  endfunction : rot_of

  function automatic logic is_known(input logic [7:0] op);
    return (op == OPC_PUSH_UP) || (op == OPC_CARRY_CLR) || (op == OPC_RETURN) || (rot_of(op) != ROT_NONE);
  endfunction : is_known

  function automatic logic [3:0] op_cycles(input logic [7:0] op, input logic alt);
    case (op)
      OPC_PUSH_UP:   return CYC_PUSH_UP;
      OPC_CARRY_CLR: return CYC_CARRY_CLR;
      OPC_RETURN:    return alt ? CYC_RET_ALT : CYC_RET_INT;
      default:       return CYC_ROTATE;
    endcase
  endfunction : op_cycles

  exec_state_t state_r;
  logic [3:0]  cnt_r;
  logic [3:0]  cyc_r;
  logic [7:0]  op_r;
  logic [7:0]  dst_r;
  logic [7:0]  src_r;
  logic [7:0]  ptr_r;
  logic [7:0]  flags_r;
  logic [15:0] sp_r;
  logic [7:0]  pc_hi_r;
  logic [7:0]  pc_lo_r;
  logic        take;
  logic        is_push;
  logic        is_ret;
  logic        is_ind;
  rot_mode_t   rmode;
  logic        rot_now;

  assign take    = exec_start_i && (state_r == ST_IDLE);
  assign is_push = (op_r == OPC_PUSH_UP);
  assign is_ret  = (op_r == OPC_RETURN);
  assign is_ind  = op_r[0];
  assign rmode   = rot_of(op_r);
  assign rot_now = (rmode != ROT_NONE) && (((state_r == ST_A) && !is_ind) || ((state_r == ST_B) && is_ind));

  rot_if rb ();
  assign rb.mode = rmode;
  assign rb.din  = rf_rdata_i;
  assign rb.cin  = flags_r[FLG_C];

  rotate_unit u_rot (
    .rb (rb)
  );

  // ==========================================================================
  // Sequencing and cycle count
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r   <= ST_IDLE;
      cnt_r     <= 4'h0;
      cyc_r     <= 4'h0;
      busy_o    <= 1'b0;
      done_o    <= 1'b0;
      illegal_o <= 1'b0;
    end
    else
    begin
      done_o    <= 1'b0;
      illegal_o <= exec_start_i && (state_r == ST_IDLE) && !is_known(opcode_i);
      case (state_r)
        ST_IDLE:
        begin
          if (take && is_known(opcode_i))
          begin
            state_r <= ST_A;
            cnt_r   <= CNT_FIRST;
            cyc_r   <= op_cycles(opcode_i, alt_stack_i);
            busy_o  <= 1'b1;
            done_o  <= (op_cycles(opcode_i, alt_stack_i) == CNT_FIRST);
          end
        end
        ST_A:    state_r <= ST_B;
        ST_B:    state_r <= ST_C;
        ST_C:    state_r <= ST_W;
        ST_W:    state_r <= ST_W;
        default: state_r <= ST_IDLE;
      endcase
      if (state_r != ST_IDLE)
      begin
        cnt_r  <= cnt_r + CNT_STEP;
        done_o <= (cnt_r + CNT_STEP == cyc_r);
        // whole instruction takes its printed cycle count
        if (cnt_r == cyc_r)
        begin
          state_r <= ST_IDLE;
          busy_o  <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Operand latch
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      op_r    <= 8'h00;
      dst_r   <= 8'h00;
      src_r   <= 8'h00;
      flags_r <= 8'h00;
      sp_r    <= 16'h0000;
    end
    else if (take)
    begin
      op_r    <= opcode_i;
      dst_r   <= dst_op_i;
      src_r   <= src_op_i;
      flags_r <= flags_i;
      sp_r    <= sp_i;
    end
  end

  // ==========================================================================
  // Register file port
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rf_addr_o  <= 8'h00;
      rf_wdata_o <= 8'h00;
      rf_we_o    <= 1'b0;
      ptr_r      <= 8'h00;
    end
    else
    begin
      rf_we_o <= 1'b0;
      if (take)
        rf_addr_o <= dst_op_i;
      else if (rot_now)
      begin
        rf_wdata_o <= rb.dout;
        rf_we_o    <= 1'b1;
      end
      else if (state_r == ST_A && is_push)
      begin
        ptr_r      <= rf_rdata_i + USP_STEP;
        rf_wdata_o <= rf_rdata_i + USP_STEP;
        rf_we_o    <= 1'b1;
      end
      // Only the rotates have an indirect form; other odd opcodes must not move the address.
      else if (state_r == ST_A && is_ind && (rmode != ROT_NONE))
        rf_addr_o <= rf_rdata_i;
      else if (state_r == ST_B && is_push)
        rf_addr_o <= src_r;
      else if (state_r == ST_C && is_push)
      begin
        // store source at the new pointer
        rf_addr_o  <= ptr_r;
        rf_wdata_o <= rf_rdata_i;
        rf_we_o    <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Stack pop and program counter
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mem_addr_o <= 16'h0000;
      pc_hi_r    <= 8'h00;
      pc_lo_r    <= 8'h00;
      pc_o       <= 16'h0000;
      pc_we_o    <= 1'b0;
      sp_o       <= 16'h0000;
      sp_we_o    <= 1'b0;
    end
    else
    begin
      pc_we_o <= 1'b0;
      sp_we_o <= 1'b0;
      if (take)
        mem_addr_o <= sp_i;
      else if (is_ret && state_r == ST_A)
      begin
        // first byte is the high byte
        pc_hi_r    <= mem_rdata_i;
        mem_addr_o <= sp_r + SP_NEXT;
      end
      else if (is_ret && state_r == ST_B)
        pc_lo_r <= mem_rdata_i;
      else if (is_ret && state_r == ST_C)
      begin
        // reload PC and advance SP by two in the same cycle
        pc_o    <= {pc_hi_r, pc_lo_r};
        pc_we_o <= 1'b1;
        sp_o    <= sp_r + SP_STEP;
        sp_we_o <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Flags; push and return never strobe them.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      flags_o    <= 8'h00;
      flags_we_o <= 1'b0;
    end
    else
    begin
      flags_we_o <= 1'b0;
      if (state_r == ST_A && op_r == OPC_CARRY_CLR)
      begin
        flags_o        <= flags_r;
        flags_o[FLG_C] <= 1'b0;
        flags_we_o     <= 1'b1;
      end
      else if (rot_now)
      begin
        // C Z S V from the rotator, D and H kept
        flags_o        <= flags_r;
        flags_o[FLG_C] <= rb.cout;
        flags_o[FLG_Z] <= rb.z;
        flags_o[FLG_S] <= rb.s;
        flags_o[FLG_V] <= rb.v;
        flags_we_o     <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Checks
  a_push_ptr_first: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_r == ST_A && is_push) |=> rf_we_o && rf_addr_o == dst_r && rf_wdata_o == $past(rf_rdata_i) + USP_STEP)
    else $error("push did not bump the pointer first");
  a_push_store_new: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_r == ST_C && is_push) |=> rf_we_o && rf_addr_o == ptr_r && rf_wdata_o == $past(rf_rdata_i))
    else $error("push store went to the wrong place");
  a_no_flag_change: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (busy_o && (is_push || is_ret)) |=> !flags_we_o)
    else $error("push or return touched flags");
  a_carry_clear_only: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_r == ST_A && op_r == OPC_CARRY_CLR) |=> flags_we_o && !flags_o[FLG_C] && flags_o[6:0] == flags_r[6:0])
    else $error("carry clear wrong");
  a_ret_pc_sp: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_r == ST_A && is_ret) |=> ##1 ##1 pc_we_o && sp_we_o && sp_o == sp_r + SP_STEP)
    else $error("return did not reload PC and SP");
  a_ret_byte_order: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_r == ST_A && is_ret) ##1 (state_r == ST_B) |-> ##2 pc_o == {$past(mem_rdata_i, 3), $past(mem_rdata_i, 2)})
    else $error("return byte order wrong");
  a_ret_cycles: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (take && opcode_i == OPC_RETURN && !alt_stack_i) |=> busy_o [*8] ##1 !busy_o)
    else $error("return cycle count wrong");
  a_rot_left: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (rot_now && rmode == ROT_RL) |=> rf_wdata_o == {$past(rf_rdata_i[6:0]), $past(rf_rdata_i[7])}
      && flags_o[FLG_C] == $past(rf_rdata_i[7]))
    else $error("rotate left wrong");
  a_rot_left_carry: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (rot_now && rmode == ROT_RLC) |=> rf_wdata_o == {$past(rf_rdata_i[6:0]), flags_r[FLG_C]}
      && flags_o[FLG_C] == $past(rf_rdata_i[7]))
    else $error("rotate left through carry wrong");
  a_rot_right: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (rot_now && rmode == ROT_RR) |=> rf_wdata_o == {$past(rf_rdata_i[0]), $past(rf_rdata_i[7:1])}
      && flags_o[FLG_C] == $past(rf_rdata_i[0]))
    else $error("rotate right wrong");
  a_rot_flags: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rot_now |=> flags_o[FLG_Z] == (rf_wdata_o == 8'h00) && flags_o[FLG_S] == rf_wdata_o[7]
      && flags_o[FLG_D] == flags_r[FLG_D] && flags_o[FLG_H] == flags_r[FLG_H])
    else $error("rotate Z S D H wrong");
  a_rot_overflow: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rot_now |=> flags_o[FLG_V] == ($past(rf_rdata_i[7]) ^ rf_wdata_o[7]))
    else $error("rotate overflow wrong");

endmodule : push_rotate_return_exec
`default_nettype wire

// [rtl/rot_if.sv]
/*
  Interface between the sequencer and the rotate unit. Purely combinational
  signals; the sequencer owns timing.
*/
`timescale 1ns/1ps
`default_nettype none
interface rot_if;
  import exec_pkg::*;
  rot_mode_t  mode;
  logic [7:0] din;
  logic       cin;
  logic [7:0] dout;
  logic       cout;
  logic       z;
  logic       s;
  logic       v;
  modport ctrl (output mode, din, cin, input dout, cout, z, s, v);
  modport alu  (input mode, din, cin, output dout, cout, z, s, v);
endinterface : rot_if
`default_nettype wire

// [rtl/rotate_unit.sv]
/*
  Combinational byte rotator with flag results. Assumes the caller samples
  the outputs on its own clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rotate_unit
  import exec_pkg::*;
(
  // Rotate operands and results
  rot_if.alu rb
);

  // ==========================================================================
  // Data path
  always_comb
  begin
    case (rb.mode)
      ROT_RL:
      begin
        rb.dout = {rb.din[6:0], rb.din[7]};
        rb.cout = rb.din[7];
      end
      ROT_RLC:
      begin
        rb.dout = {rb.din[6:0], rb.cin};
        rb.cout = rb.din[7];
      end
      ROT_RR:
      begin
        rb.dout = {rb.din[0], rb.din[7:1]};
        rb.cout = rb.din[0];
      end
      default:
      begin
        rb.dout = rb.din;
        rb.cout = rb.cin;
      end
    endcase
  end

  assign rb.z = (rb.dout == 8'h00);
  assign rb.s = rb.dout[7];
  assign rb.v = rb.din[7] ^ rb.dout[7];

endmodule : rotate_unit
`default_nettype wire
